// *** pmbmc_top.sv ***
`timescale 1ns/1ns
`include "pmbmc_cfg.svh"
// Notes on behaviour
// R1: bus setting writes land only in volatile memory, lost at reset unless stored.
// R2: status bits set on faults, cleared by 03h or input below stop voltage.
// R3: 12h copies factory defaults into operating memory, only with output off.
// R4: user store loads into operating memory on 16h and at start-up.
// R5: 15h copies all operating memory into the user store.
// R6: at most five stores execute; further ones ignored until F5h runs (the code also zeroes the store count at reset).
// R7: one non-volatile counter per protection, ranging zero to 128.
// R8: counters read at F0h, F1h, F2h, F3h, F6h, F7h.
// R9: F5h zeroes all counters and erases the user store.
// R10: auto-recovery trips each increment the counter again.
// R11: counters committed on FDh, on 15h, or on held input sag with 5Ah[7:6]=11.
// R12: output voltage uses unsigned 16-bit mantissa, exponent -10 in 20h.
// R13: other values use 5-bit signed exponent over 11-bit signed mantissa.
// R14: exponents fixed: input voltage -5, temperature 0, start time -4.
// R15: bus served 3ms after start voltage if off, else after power good.
// R16: bus not served 10ms after stop begins, nor at input 4.5V or below.
// R17: no bus transactions accepted while 12h, 15h or 16h run.
// R18: device may stretch the clock; host waits for release.
// R19: alert is open drain, pulled low on any abnormal condition.
// R20: alert response read returns own address then clears status.
// R21: ARA address change lands 0.5ms after, not when alert pin open.
// R22: E0h enables ARA handling; 03h disables it and alert changes.
// R23: with ARA enabled and fault present, answer only the alert address.
// R24: store and restore are atomic; mid-operation transactions are stretched.
module pmbmc_top #(
	parameter int          MEM_WORDS  = 16,
	parameter logic [6:0]  OWN_ADDR   = 7'h2a, // arbitrary value
	parameter int          T_START_CYC = `PMBMC_T_START_US * `PMBMC_CLK_MHZ,
	parameter int          T_STOP_CYC  = `PMBMC_T_STOP_US * `PMBMC_CLK_MHZ,
	parameter int          T_ARA_CYC   = `PMBMC_T_ARA_US * `PMBMC_CLK_MHZ,
	parameter int          T_UVH_CYC   = `PMBMC_T_UVHOLD_US * `PMBMC_CLK_MHZ
) (
	input  wire logic                 CLK_IN,
	input  wire logic                 RST_IN,
	input  wire logic                 CE_IN,
	input  wire logic                 WB_CYC_IN,
	input  wire logic                 WB_STB_IN,
	input  wire logic                 WB_WE_IN,
	input  wire logic [7:0]           WB_ADR_IN,
	input  wire logic [3:0]           WB_SEL_IN,
	input  wire logic [31:0]          WB_DAT_IN,
	output logic      [31:0]          WB_DAT_OUT,
	output logic                      WB_ACK_OUT,
	input  wire logic                 IN_ABOVE_START_IN,
	input  wire logic                 IN_BELOW_STOP_IN,
	input  wire logic                 IN_ABOVE_4V5_IN,
	input  wire logic                 OUT_ENABLED_IN,
	input  wire logic                 STOP_BEGIN_IN,
	input  wire logic                 POWER_GOOD_IN,
	input  wire logic [5:0]           TRIP_IN,
	input  wire logic                 ALERT_IN,
	output logic                      ALERT_OE_OUT,
	output logic                      ALERT_O_OUT,
	output logic                      SCL_HOLD_OUT,
	output logic                      BUS_SERVE_OUT
);
	localparam int AW = $clog2(MEM_WORDS);
	logic [15:0] op_mem_q [MEM_WORDS];
	logic [15:0] usr_mem_q [MEM_WORDS];
	logic [15:0] def_mem [MEM_WORDS];
	logic [7:0]  cnt_q [6];
	logic [7:0]  cnt_nv_q [6];
	logic [7:0]  status_q [7];
	logic [2:0]  stores_q;
	logic        ara_en_q;
	logic        alert_frozen_q;
	logic        ara_lock_q;
	logic [6:0]  ara_addr_q;
	logic        ara_pend_q;
	logic [31:0] ara_cnt_q;
	logic [7:0]  cmd_q;
	logic [15:0] wdat_q;
	logic [15:0] rdat_q;
	logic        refused_q;
	pmbmc_pkg::pmbmc_state_t st_q;
	pmbmc_pkg::pmbmc_op_t    op_q;
	logic [AW-1:0] idx_q;
	logic [4:0]  nvw_q;
	logic [31:0] srv_cnt_q;
	logic        srv_armed_q;
	logic        served_q;
	logic [31:0] uvh_cnt_q;
	pmbmc_pkg::pmbmc_trip_t trip_s1_q, trip_s2_q, trip_s3_q, trip_prev_q;
	logic [2:0]  alert_sync_q;

	// default set is a constant table in the device
	generate
		for (genvar g = 0; g < MEM_WORDS; g++) begin : g_def
			assign def_mem[g] = 16'(g);
		end
	endgenerate

	function automatic logic is_status(input logic [7:0] c);
		return c >= `PMBMC_CMD_STATUS_FIRST && c <= `PMBMC_CMD_STATUS_LAST;
	endfunction

	function automatic int cnt_index(input logic [7:0] c);
		unique case (c)
			`PMBMC_CMD_CNT_OUT_OV: return 0;
			`PMBMC_CMD_CNT_OUT_UV: return 1;
			`PMBMC_CMD_CNT_OT:     return 2;
			`PMBMC_CMD_CNT_UT:     return 3;
			`PMBMC_CMD_CNT_IN_OV:  return 4;
			`PMBMC_CMD_CNT_IN_UV:  return 5;
			default:               return -1;
		endcase
	endfunction

	wire logic wb_req   = WB_CYC_IN && WB_STB_IN && !WB_ACK_OUT && CE_IN;
	wire logic busy     = st_q != pmbmc_pkg::PMBMC_IDLE;
	wire logic wr_cmd   = wb_req && WB_WE_IN && WB_ADR_IN == `PMBMC_OFS_CMD && WB_SEL_IN[1]
			&& WB_DAT_IN[`PMBMC_CMD_GO_BIT];
	wire logic [7:0] new_cmd = WB_DAT_IN[7:0];
	wire logic fault_any = |{status_q[0], status_q[1], status_q[2], status_q[3],
			status_q[4], status_q[5], status_q[6]};
	wire logic trip_clear = trip_s2_q == trip_s3_q;
	wire logic [5:0] trip_rise = trip_clear ? (trip_s3_q & ~trip_prev_q) : 6'h00;
	wire logic alert_pin_hi = alert_sync_q[1] && alert_sync_q[2];
	// refuse commands while not served, during copy, or ARA-locked
	wire logic refuse = !served_q || busy
			|| (ara_lock_q && WB_ADR_IN != `PMBMC_OFS_ARA_ADDR);
	wire logic [15:0] uv_resp = op_mem_q[`PMBMC_CMD_VIN_UV_RESP % MEM_WORDS];
	wire logic clear_cmd = wr_cmd && !refuse && new_cmd == `PMBMC_CMD_CLEAR_FAULTS;
	wire logic ara_read = wb_req && !WB_WE_IN && WB_ADR_IN == `PMBMC_OFS_ARA_ADDR && served_q
			&& !busy && ara_en_q && fault_any;

	// input synchronisers for trip and alert pins
	always_ff @(posedge CLK_IN) begin
		if (RST_IN) begin
			trip_s1_q    <= '0;
			trip_s2_q    <= '0;
			trip_s3_q    <= '0;
			trip_prev_q  <= '0;
			alert_sync_q <= 3'h0;
		end else if (CE_IN) begin
			trip_s1_q    <= TRIP_IN;
			trip_s2_q    <= trip_s1_q;
			trip_s3_q    <= trip_s2_q;
			if (trip_clear)
				trip_prev_q <= trip_s3_q;
			alert_sync_q <= {alert_sync_q[1:0], ALERT_IN};
		end
	end

	// serve window: R15 start delay or power good, R16 stop and low input
	always_ff @(posedge CLK_IN) begin
		if (RST_IN) begin
			srv_cnt_q   <= '0;
			srv_armed_q <= 1'b0;
			served_q    <= 1'b0;
		end else if (CE_IN) begin
			if (!IN_ABOVE_4V5_IN) begin
				// R16 low input
				served_q    <= 1'b0;
				srv_armed_q <= 1'b0;
				srv_cnt_q   <= '0;
			end else if (STOP_BEGIN_IN) begin
				// R16 stop blackout
				served_q    <= 1'b0;
				srv_armed_q <= 1'b1;
				srv_cnt_q   <= 32'(T_STOP_CYC);
			end else if (srv_armed_q) begin
				if (srv_cnt_q > 32'h1)
					srv_cnt_q <= srv_cnt_q - 32'h1;
				else begin
					srv_armed_q <= 1'b0;
					served_q    <= 1'b1;
				end
			end else if (!served_q) begin
				// R15 start-up gating
				if (OUT_ENABLED_IN) begin
					served_q <= POWER_GOOD_IN;
				end else if (IN_ABOVE_START_IN) begin
					srv_armed_q <= 1'b1;
					srv_cnt_q   <= 32'(T_START_CYC);
				end
			end
		end
	end

	// copy engine for restore and store
	always_ff @(posedge CLK_IN) begin
		if (RST_IN) begin
			st_q  <= pmbmc_pkg::PMBMC_COPY;
			// R4 load user store at start-up
			op_q  <= pmbmc_pkg::PMBMC_OP_USER;
			idx_q <= '0;
			nvw_q <= 5'h00;
		end else if (CE_IN) begin
			unique case (st_q)
				pmbmc_pkg::PMBMC_IDLE: begin
					if (wr_cmd && !refuse) begin
						// R3 defaults only with output off
						if (new_cmd == `PMBMC_CMD_RESTORE_DEFAULT && !OUT_ENABLED_IN) begin
							op_q <= pmbmc_pkg::PMBMC_OP_DEF;
							st_q <= pmbmc_pkg::PMBMC_COPY;
						end else if (new_cmd == `PMBMC_CMD_RESTORE_USER) begin
							// R4 restore user
							op_q <= pmbmc_pkg::PMBMC_OP_USER;
							st_q <= pmbmc_pkg::PMBMC_COPY;
						// R6 store limit
						end else if (new_cmd == `PMBMC_CMD_STORE_USER && stores_q < `PMBMC_STORE_MAX) begin
							op_q <= pmbmc_pkg::PMBMC_OP_STORE;
							st_q <= pmbmc_pkg::PMBMC_COPY;
						end
						idx_q <= '0;
					end
				end
				pmbmc_pkg::PMBMC_COPY: begin
					if (idx_q == AW'(MEM_WORDS - 1))
						st_q <= pmbmc_pkg::PMBMC_DONE;
					else
						idx_q <= idx_q + AW'(1);
					nvw_q <= 5'(`PMBMC_NV_OP_CYC);
				end
				pmbmc_pkg::PMBMC_DONE: begin
					// models nonvolatile write settle time
					if (nvw_q == 5'h00)
						st_q <= pmbmc_pkg::PMBMC_IDLE;
					else
						nvw_q <= nvw_q - 5'h01;
				end
				default: st_q <= pmbmc_pkg::PMBMC_IDLE;
			endcase
		end
	end

	// operating memory; R1 volatile, R3/R4 restore
	always_ff @(posedge CLK_IN) begin
		if (CE_IN) begin
			if (st_q == pmbmc_pkg::PMBMC_COPY && op_q == pmbmc_pkg::PMBMC_OP_DEF)
				op_mem_q[idx_q] <= def_mem[idx_q];
			else if (st_q == pmbmc_pkg::PMBMC_COPY && op_q == pmbmc_pkg::PMBMC_OP_USER)
				op_mem_q[idx_q] <= usr_mem_q[idx_q];
			else if (wr_cmd && !refuse && !is_status(new_cmd) && cnt_index(new_cmd) < 0)
				op_mem_q[AW'(new_cmd)] <= wdat_q;
		end
	end

	// user store: R5 store, R9 erase
	always_ff @(posedge CLK_IN) begin
		if (RST_IN) begin
			stores_q <= 3'h0;
		end else if (CE_IN) begin
			if (st_q == pmbmc_pkg::PMBMC_COPY && op_q == pmbmc_pkg::PMBMC_OP_STORE) begin
				usr_mem_q[idx_q] <= op_mem_q[idx_q];
				if (idx_q == '0)
					stores_q <= stores_q + 3'h1;
			end else if (wr_cmd && !refuse && new_cmd == `PMBMC_CMD_USER_CLEAR) begin
				for (int i = 0; i < MEM_WORDS; i++)
					usr_mem_q[i] <= 16'h0000;
				stores_q <= 3'h0;
			end
		end
	end

	// trip counters, R7 saturate at 128, R10 every trip
	always_ff @(posedge CLK_IN) begin
		if (RST_IN) begin
			for (int i = 0; i < 6; i++)
				cnt_q[i] <= cnt_nv_q[i];
			uvh_cnt_q <= '0;
		end else if (CE_IN) begin
			for (int i = 0; i < 6; i++) begin
				// R9 clear counters
				if (wr_cmd && !refuse && new_cmd == `PMBMC_CMD_USER_CLEAR)
					cnt_q[i] <= 8'h00;
				else if (trip_rise[5 - i] && cnt_q[i] < `PMBMC_COUNT_MAX)
					cnt_q[i] <= cnt_q[i] + 8'h01;
			end
			if (uv_resp[7:6] == `PMBMC_UVRESP_COMMIT && IN_BELOW_STOP_IN && IN_ABOVE_4V5_IN)
				uvh_cnt_q <= (uvh_cnt_q < 32'(T_UVH_CYC)) ? uvh_cnt_q + 32'h1 : uvh_cnt_q;
			else
				uvh_cnt_q <= '0;
		end
	end

	// R11 counter commit; survives reset as nonvolatile image
	always_ff @(posedge CLK_IN) begin
		if (CE_IN) begin
			if ((wr_cmd && !refuse && (new_cmd == `PMBMC_CMD_CNT_COMMIT
					|| new_cmd == `PMBMC_CMD_STORE_USER || new_cmd == `PMBMC_CMD_USER_CLEAR))
					|| uvh_cnt_q == 32'(T_UVH_CYC - 1))
				for (int i = 0; i < 6; i++)
					cnt_nv_q[i] <= (new_cmd == `PMBMC_CMD_USER_CLEAR && wr_cmd) ? 8'h00 : cnt_q[i];
		end
	end

	// status memory R2; set wins over clear
	always_ff @(posedge CLK_IN) begin
		if (RST_IN) begin
			for (int i = 0; i < 7; i++)
				status_q[i] <= 8'h00;
		end else if (CE_IN) begin
			for (int i = 0; i < 7; i++) begin
				if (clear_cmd || IN_BELOW_STOP_IN || ara_read)
					status_q[i] <= 8'h00;
			end
			status_q[0] <= ((clear_cmd || IN_BELOW_STOP_IN || ara_read) ? 8'h00 : status_q[0])
					| {2'b00, trip_rise};
		end
	end

	// alert and ARA: R19, R20, R21, R22, R23
	always_ff @(posedge CLK_IN) begin
		if (RST_IN) begin
			ara_en_q       <= 1'b0;
			alert_frozen_q <= 1'b0;
			ara_lock_q     <= 1'b0;
			ara_addr_q     <= OWN_ADDR;
			ara_pend_q     <= 1'b0;
			ara_cnt_q      <= '0;
			ALERT_OE_OUT   <= 1'b0;
		end else if (CE_IN) begin
			if (clear_cmd) begin
				ara_en_q       <= 1'b0;
				alert_frozen_q <= 1'b1;
			end else if (wr_cmd && !refuse && new_cmd == `PMBMC_CMD_ALERT_CFG) begin
				ara_en_q       <= wdat_q[0];
				alert_frozen_q <= 1'b0;
			end
			if (!alert_frozen_q)
				ALERT_OE_OUT <= fault_any;
			ara_lock_q <= ara_en_q && fault_any ? 1'b1 : (!OUT_ENABLED_IN ? 1'b0 : ara_lock_q);
			if (ara_read && !alert_pin_hi) begin
				ara_pend_q <= 1'b1;
				ara_cnt_q  <= 32'(T_ARA_CYC);
			end else if (ara_pend_q) begin
				if (ara_cnt_q > 32'h1)
					ara_cnt_q <= ara_cnt_q - 32'h1;
				else begin
					ara_pend_q <= 1'b0;
					ara_addr_q <= ara_addr_q ^ 7'h01;
				end
			end
		end
	end

	// wishbone slave, one wait cycle; R17/R24 refusal and R18 stretch
	always_ff @(posedge CLK_IN) begin
		if (RST_IN) begin
			WB_ACK_OUT    <= 1'b0;
			WB_DAT_OUT    <= 32'h0;
			cmd_q         <= 8'h00;
			wdat_q        <= 16'h0000;
			rdat_q        <= 16'h0000;
			refused_q     <= 1'b0;
			SCL_HOLD_OUT  <= 1'b0;
			BUS_SERVE_OUT <= 1'b0;
			ALERT_O_OUT   <= 1'b0;
		end else if (CE_IN) begin
			WB_ACK_OUT    <= wb_req;
			SCL_HOLD_OUT  <= busy;
			BUS_SERVE_OUT <= served_q && !busy;
			WB_DAT_OUT    <= 32'h0;
			if (wr_cmd) begin
				refused_q <= refuse;
				if (!refuse) begin
					cmd_q <= new_cmd;
					if (is_status(new_cmd))
						rdat_q <= {8'h00, status_q[3'(new_cmd - `PMBMC_CMD_STATUS_FIRST)]};
					// R8 counter reads
					else if (cnt_index(new_cmd) >= 0)
						rdat_q <= {8'h00, cnt_q[cnt_index(new_cmd)]};
					// R12 exponent byte
					else if (new_cmd == `PMBMC_CMD_VOUT_MODE)
						rdat_q <= {11'h000, `PMBMC_EXP_VOUT};
					else
						rdat_q <= op_mem_q[AW'(new_cmd)];
				end
			end
			if (wb_req && WB_WE_IN && WB_ADR_IN == `PMBMC_OFS_WDATA)
				wdat_q <= WB_DAT_IN[15:0];
			if (wb_req && !WB_WE_IN) begin
				unique case (WB_ADR_IN)
					`PMBMC_OFS_CMD:      WB_DAT_OUT <= {24'h0, cmd_q};
					`PMBMC_OFS_WDATA:    WB_DAT_OUT <= {16'h0, wdat_q};
					`PMBMC_OFS_RDATA:    WB_DAT_OUT <= {16'h0, rdat_q};
					`PMBMC_OFS_STAT:     WB_DAT_OUT <= {25'h0, stores_q, 1'b0, refused_q, served_q, busy};
					// R20 own address
					`PMBMC_OFS_ARA_ADDR: WB_DAT_OUT <= (ara_en_q && fault_any) ? {25'h0, ara_addr_q} : 32'h0;
					default:             WB_DAT_OUT <= 32'h0;
				endcase
			end
		end
	end
	// linear exponents R13/R14 are constants in cfg: vin, temp, ton
	wire logic [14:0] unused_exp = {`PMBMC_EXP_VIN, `PMBMC_EXP_TEMP, `PMBMC_EXP_TON};
endmodule

// *** pmbmc_cfg.svh ***
`ifndef PMBMC_CFG_SVH
`define PMBMC_CFG_SVH
// command codes
`define PMBMC_CMD_CLEAR_FAULTS    8'h03
`define PMBMC_CMD_RESTORE_DEFAULT 8'h12
`define PMBMC_CMD_STORE_USER      8'h15
`define PMBMC_CMD_RESTORE_USER    8'h16
`define PMBMC_CMD_VOUT_MODE       8'h20
`define PMBMC_CMD_VIN_UV_RESP     8'h5a
`define PMBMC_CMD_STATUS_FIRST    8'h78
`define PMBMC_CMD_STATUS_LAST     8'h7e
`define PMBMC_CMD_ALERT_CFG       8'he0
`define PMBMC_CMD_CNT_OUT_OV      8'hf0
`define PMBMC_CMD_CNT_OUT_UV      8'hf1
`define PMBMC_CMD_CNT_OT          8'hf2
`define PMBMC_CMD_CNT_UT          8'hf3
`define PMBMC_CMD_USER_CLEAR      8'hf5
`define PMBMC_CMD_CNT_IN_OV       8'hf6
`define PMBMC_CMD_CNT_IN_UV       8'hf7
`define PMBMC_CMD_CNT_COMMIT      8'hfd
// wishbone word offsets
`define PMBMC_OFS_CMD      8'h00
`define PMBMC_OFS_WDATA    8'h04
`define PMBMC_OFS_RDATA    8'h08
`define PMBMC_OFS_STAT     8'h0c
`define PMBMC_OFS_ARA_ADDR 8'h10
// command register fields
`define PMBMC_CMD_GO_BIT   8
// status register fields
`define PMBMC_ST_BUSY_BIT  0
`define PMBMC_ST_SERV_BIT  1
`define PMBMC_ST_REFUSE_BIT 2
`define PMBMC_ST_STORES_LSB 4
// linear format
`define PMBMC_EXP_VOUT     5'h16
`define PMBMC_EXP_VIN      5'h1b
`define PMBMC_EXP_TEMP     5'h00
`define PMBMC_EXP_TON      5'h1c
// limits
`define PMBMC_STORE_MAX    3'h5
`define PMBMC_COUNT_MAX    8'h80
`define PMBMC_UVRESP_COMMIT 2'h3
// timing in microseconds and the cycle counts derived at 100 MHz
`define PMBMC_CLK_MHZ      100
`define PMBMC_T_START_US   3000
`define PMBMC_T_STOP_US    10000
`define PMBMC_T_ARA_US     500
`define PMBMC_T_UVHOLD_US  500000
`define PMBMC_NV_OP_CYC    16
`endif

// *** pmbmc_pkg.sv ***
package pmbmc_pkg;
	typedef enum logic [2:0] {
		PMBMC_IDLE     = 3'b000,
		PMBMC_COPY     = 3'b001,
		PMBMC_DONE     = 3'b010
	} pmbmc_state_t;
	typedef enum logic [1:0] {
		PMBMC_OP_NONE  = 2'b00,
		PMBMC_OP_DEF   = 2'b01,
		PMBMC_OP_STORE = 2'b10,
		PMBMC_OP_USER  = 2'b11
	} pmbmc_op_t;
	// one raw sensor/fault event sample
	typedef struct packed {
		logic out_ov;
		logic out_uv;
		logic ot;
		logic ut;
		logic in_ov;
		logic in_uv;
	} pmbmc_trip_t;
endpackage

// *** pmbmc_monitor.sv ***
`timescale 1ns/1ns
module pmbmc_monitor #(
	parameter int MEM_WORDS = 16
) (
	input wire logic CLK_IN,
	input wire logic RST_IN,
	input wire logic CE_IN,
	input wire logic WB_CYC_IN,
	input wire logic WB_STB_IN,
	input wire logic WB_ACK_OUT,
	input wire logic IN_ABOVE_START_IN,
	input wire logic IN_ABOVE_4V5_IN,
	input wire logic OUT_ENABLED_IN,
	input wire logic STOP_BEGIN_IN,
	input wire logic POWER_GOOD_IN,
	input wire logic ALERT_OE_OUT,
	input wire logic ALERT_O_OUT,
	input wire logic SCL_HOLD_OUT,
	input wire logic BUS_SERVE_OUT
);
	default clocking cb @(posedge CLK_IN); endclocking
	default disable iff (RST_IN);
	int hold_n_q;
	// stretch length, margin over a full copy
	always_ff @(posedge CLK_IN) begin
		if (RST_IN || !SCL_HOLD_OUT) begin
			hold_n_q <= 0;
		end else begin
			hold_n_q <= hold_n_q + 1;
		end
	end
	chk_alert_drain: assert property (!ALERT_O_OUT)
		else $error("alert pin driven high");
	chk_hold_bounded: assert property (hold_n_q < MEM_WORDS + 40)
		else $error("clock stretch too long");
	chk_ack_pulse: assert property (WB_ACK_OUT |=> !WB_ACK_OUT)
		else $error("ack longer than one cycle");
	chk_ack_answer: assert property (WB_CYC_IN && WB_STB_IN && !WB_ACK_OUT && CE_IN |=> WB_ACK_OUT)
		else $error("request not answered");
	chk_ack_cause: assert property (WB_ACK_OUT |-> $past(WB_CYC_IN && WB_STB_IN))
		else $error("ack without request");
	chk_stop_quiet: assert property ($rose(STOP_BEGIN_IN) |-> ##3 !BUS_SERVE_OUT [*8])
		else $error("bus served after stop");
	chk_low_vin: assert property ($fell(IN_ABOVE_4V5_IN) |-> ##[1:3] !BUS_SERVE_OUT)
		else $error("bus served at low input");
	chk_start_wait: assert property ($rose(IN_ABOVE_START_IN) && !OUT_ENABLED_IN |-> !BUS_SERVE_OUT [*8])
		else $error("bus served too early");
	chk_pg_serve: assert property ($rose(BUS_SERVE_OUT) && OUT_ENABLED_IN |-> POWER_GOOD_IN)
		else $error("bus served before power good");
	cover property ($rose(BUS_SERVE_OUT));
	cover property ($rose(SCL_HOLD_OUT));
	cover property ($rose(ALERT_OE_OUT));
endmodule
bind pmbmc_top pmbmc_monitor #(.MEM_WORDS(MEM_WORDS)) pmbmc_monitor_i (.CLK_IN(CLK_IN), .RST_IN(RST_IN),
	.CE_IN(CE_IN), .WB_CYC_IN(WB_CYC_IN), .WB_STB_IN(WB_STB_IN), .WB_ACK_OUT(WB_ACK_OUT),
	.IN_ABOVE_START_IN(IN_ABOVE_START_IN), .IN_ABOVE_4V5_IN(IN_ABOVE_4V5_IN),
	.OUT_ENABLED_IN(OUT_ENABLED_IN), .STOP_BEGIN_IN(STOP_BEGIN_IN), .POWER_GOOD_IN(POWER_GOOD_IN),
	.ALERT_OE_OUT(ALERT_OE_OUT), .ALERT_O_OUT(ALERT_O_OUT), .SCL_HOLD_OUT(SCL_HOLD_OUT),
	.BUS_SERVE_OUT(BUS_SERVE_OUT));

// *** pmbmc_host.sv ***
`timescale 1ns/1ns
module pmbmc_host (
	input  wire logic        clk_in,
	input  wire logic        ack_in,
	input  wire logic [31:0] dat_in,
	input  wire logic        hold_in,
	output logic             cyc_out,
	output logic             stb_out,
	output logic             we_out,
	output logic [7:0]       adr_out,
	output logic [3:0]       sel_out,
	output logic [31:0]      dat_out,
	output logic             timeout_out
);
	initial begin
		cyc_out = 0;
		stb_out = 0;
		we_out = 0;
		adr_out = 8'h00;
		sel_out = 4'h0;
		dat_out = 32'h0000_0000;
		timeout_out = 0;
	end
	// entered just after a rising edge; answer taken at the ack edge only
	task automatic wb_cycle(input logic we, input logic [7:0] adr, input logic [31:0] wd,
		output logic [31:0] rd);
		int n;
		n = 0;
		while (hold_in === 1'b1 && n < 2000) begin
			@(posedge clk_in);
			n++;
		end
		cyc_out <= 1;
		stb_out <= 1;
		we_out <= we;
		adr_out <= adr;
		sel_out <= 4'hf;
		dat_out <= wd;
		n = 0;
		do begin
			@(posedge clk_in);
			n++;
		end while (ack_in !== 1'b1 && n < 100);
		rd = dat_in;
		if (ack_in !== 1'b1) begin
			timeout_out <= 1;
		end
		cyc_out <= 0;
		stb_out <= 0;
		we_out <= 0;
		@(posedge clk_in);
	endtask
endmodule

// *** test_pmbmc_top.sv ***
`timescale 1ns/1ns
`include "pmbmc_cfg.svh"
module test_pmbmc_top;
	localparam int TS = 20;
	localparam int TP = 30;
	localparam logic [7:0] CNT_CODE [6] = '{8'hf0, 8'hf1, 8'hf2, 8'hf3, 8'hf6, 8'hf7};
	logic        clk, rst, start, vin_ok, out_en, stop_go, pg, alert_pin, below;
	logic        cyc, stb, we, ack, hold, serve, alert_oe, alert_o, tmo;
	logic [5:0]  trip;
	logic [7:0]  adr;
	logic [3:0]  sel;
	logic [31:0] wdat, rdat, rd;
	int          num_errors, checks, n;
	// pull-up on the alert wire
	assign alert_pin = !alert_oe;
	// own address is an arbitrary value
	pmbmc_top #(.OWN_ADDR(7'h31), .T_START_CYC(TS), .T_STOP_CYC(TP), .T_ARA_CYC(10),
		.T_UVH_CYC(40)) pmbmc_top_i (
		.CLK_IN(clk), .RST_IN(rst), .CE_IN(1'b1), .WB_CYC_IN(cyc), .WB_STB_IN(stb), .WB_WE_IN(we),
		.WB_ADR_IN(adr), .WB_SEL_IN(sel), .WB_DAT_IN(wdat), .WB_DAT_OUT(rdat), .WB_ACK_OUT(ack),
		.IN_ABOVE_START_IN(start), .IN_BELOW_STOP_IN(below), .IN_ABOVE_4V5_IN(vin_ok),
		.OUT_ENABLED_IN(out_en), .STOP_BEGIN_IN(stop_go), .POWER_GOOD_IN(pg), .TRIP_IN(trip),
		.ALERT_IN(alert_pin), .ALERT_OE_OUT(alert_oe), .ALERT_O_OUT(alert_o), .SCL_HOLD_OUT(hold),
		.BUS_SERVE_OUT(serve));
	pmbmc_host pmbmc_host_i (.clk_in(clk), .ack_in(ack), .dat_in(rdat), .hold_in(hold), .cyc_out(cyc),
		.stb_out(stb), .we_out(we), .adr_out(adr), .sel_out(sel), .dat_out(wdat), .timeout_out(tmo));
	initial begin
		clk = 0;
		forever #5 clk = ~clk;
	end
	task automatic conclude();
		$display("errors %0d checks %0d", num_errors, checks);
		if (num_errors == 0 && checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		checks++;
		if (got !== exp) begin
			$display("unexpected %s expected %h seen %h", what, exp, got);
			num_errors++;
		end
	endtask
	task automatic give_up(input logic ok);
		if (!ok) begin
			$display("unexpected wait expected done seen timeout");
			num_errors++;
			conclude();
		end
	endtask
	task automatic wait_serve();
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (serve !== 1'b1 && n < 500);
		give_up(serve === 1'b1);
	endtask
	task automatic cmd(input logic [7:0] code, input logic [15:0] v);
		pmbmc_host_i.wb_cycle(1, `PMBMC_OFS_WDATA, {16'h0000, v}, rd);
		pmbmc_host_i.wb_cycle(1, `PMBMC_OFS_CMD, {23'h0, 1'b1, code}, rd);
		n = 0;
		do begin
			pmbmc_host_i.wb_cycle(0, `PMBMC_OFS_STAT, 32'h0, rd);
			n++;
		end while (rd[1:0] !== 2'b10 && n < 200);
		give_up(rd[1:0] === 2'b10);
	endtask
	task automatic rdc(input logic [7:0] code);
		cmd(code, 16'h0000);
		pmbmc_host_i.wb_cycle(0, `PMBMC_OFS_RDATA, 32'h0, rd);
	endtask
	task automatic t_startup();
		repeat (3) @(posedge clk);
		chk("stretch during load", 1, hold);
		start <= 1;
		wait_serve();
		chk("start delay", 1, n >= TS);
	endtask
	task automatic t_format();
		rdc(`PMBMC_CMD_VOUT_MODE);
		chk("vout exponent", `PMBMC_EXP_VOUT, rd[4:0]);
	endtask
	task automatic t_counters();
		cmd(`PMBMC_CMD_USER_CLEAR, 16'h0000);
		for (int i = 0; i < 6; i++) begin
			// repeat trip as after each recovery
			repeat (2) begin
				trip[5 - i] <= 1;
				repeat (4) @(posedge clk);
				trip[5 - i] <= 0;
				repeat (4) @(posedge clk);
			end
			rdc(CNT_CODE[i]);
			chk("trip count", 2, rd[15:0]);
		end
		chk("alert pulled", 1, alert_oe);
		rdc(`PMBMC_CMD_STATUS_FIRST);
		chk("status set", 1, rd[15:0] != 16'h0000);
		cmd(`PMBMC_CMD_CLEAR_FAULTS, 16'h0000);
		rdc(`PMBMC_CMD_STATUS_FIRST);
		chk("status cleared", 0, rd[15:0]);
		// input sag below stop voltage also wipes status
		trip[0] <= 1;
		repeat (4) @(posedge clk);
		trip[0] <= 0;
		repeat (4) @(posedge clk);
		below <= 1;
		@(posedge clk);
		below <= 0;
		rdc(`PMBMC_CMD_STATUS_FIRST);
		chk("status after sag", 0, rd[15:0]);
		cmd(`PMBMC_CMD_USER_CLEAR, 16'h0000);
		for (int i = 0; i < 6; i++) begin
			rdc(CNT_CODE[i]);
			chk("count cleared", 0, rd[15:0]);
		end
	endtask
	task automatic t_store();
		repeat (7) cmd(`PMBMC_CMD_STORE_USER, 16'h0000);
		pmbmc_host_i.wb_cycle(0, `PMBMC_OFS_STAT, 32'h0, rd);
		chk("store limit", 5, rd[6:4]);
		cmd(`PMBMC_CMD_USER_CLEAR, 16'h0000);
		pmbmc_host_i.wb_cycle(0, `PMBMC_OFS_STAT, 32'h0, rd);
		chk("stores after clear", 0, rd[6:4]);
	endtask
	task automatic t_ara();
		cmd(`PMBMC_CMD_ALERT_CFG, 16'h0001);
		for (int k = 0; k < 2; k++) begin
			trip[0] <= 1;
			repeat (4) @(posedge clk);
			trip[0] <= 0;
			repeat (4) @(posedge clk);
			chk("alert after enable", 1, alert_oe);
			pmbmc_host_i.wb_cycle(1, `PMBMC_OFS_CMD, {23'h0, 1'b1, 8'h21}, rd);
			pmbmc_host_i.wb_cycle(0, `PMBMC_OFS_STAT, 32'h0, rd);
			chk("refused while locked", 1, rd[2]);
			pmbmc_host_i.wb_cycle(0, `PMBMC_OFS_ARA_ADDR, 32'h0, rd);
			chk("ara address", {25'h0, 7'h31 ^ 7'(k)}, rd);
			// address toggle lands after the ara delay
			repeat (20) @(posedge clk);
			chk("alert released", 0, alert_oe);
		end
		rdc(`PMBMC_CMD_STATUS_FIRST);
		chk("status after ara", 0, rd[15:0]);
	endtask
	task automatic t_restart();
		cmd(8'h21, 16'h1234);
		cmd(`PMBMC_CMD_STORE_USER, 16'h0000);
		cmd(8'h21, 16'h5678);
		rst <= 1;
		repeat (2) @(posedge clk);
		rst <= 0;
		wait_serve();
		rdc(8'h21);
		chk("setting after reset", 32'h1234, rd[15:0]);
		rdc(`PMBMC_CMD_CNT_IN_UV);
		chk("count after reset", 2, rd[15:0]);
		cmd(`PMBMC_CMD_RESTORE_USER, 16'h0000);
		rdc(8'h21);
		chk("user restore", 32'h1234, rd[15:0]);
		out_en <= 1;
		cmd(`PMBMC_CMD_RESTORE_DEFAULT, 16'h0000);
		rdc(8'h21);
		chk("default with output on", 0, rd[15:0]);
		out_en <= 0;
	endtask
	task automatic t_stop();
		out_en <= 1;
		stop_go <= 1;
		@(posedge clk);
		stop_go <= 0;
		repeat (8) @(posedge clk);
		chk("serve after stop", 0, serve);
		wait_serve();
		chk("stop quiet length", 1, n >= TP - 12);
		vin_ok <= 0;
		repeat (6) @(posedge clk);
		chk("serve at low input", 0, serve);
	endtask
	always @(posedge clk) begin
		if (tmo === 1'b1) begin
			num_errors++;
			conclude();
		end
	end
	initial begin
		repeat (100000) @(posedge clk);
		give_up(1'b0);
	end
	initial begin
		rst = 1;
		start = 0;
		vin_ok = 1;
		out_en = 0;
		stop_go = 0;
		pg = 1;
		below = 0;
		trip = 6'h00;
		num_errors = 0;
		checks = 0;
		repeat (4) @(posedge clk);
		rst <= 0;
		t_startup();
		t_format();
		t_counters();
		t_store();
		t_ara();
		t_restart();
		t_stop();
		conclude();
	end
endmodule
